// file: core/trrc_core.sv
// Reload buffering, repetition counter and six capture channels.
// Assumes the main counter and its overflow/underflow pulses come from outside.
// Assumes one-cycle register strobes and channel pins on the same clock.
`timescale 1ns/1ns
module trrc_core
#(
	parameter int COUNT_W = 16,
	parameter int REPEAT_W = 8
)
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [COUNT_W-1:0] MAIN_COUNTER,
	input wire logic OVERFLOW,
	input wire logic UNDERFLOW,
	input wire logic CENTER_MODE,
	input wire logic DOWN_DIR,
	input wire logic SLAVE_RESET,
	input wire logic [5:0] CH_IN,
	output logic UPDATE_EVENT,
	output logic [COUNT_W-1:0] ACTIVE_RELOAD,
	output logic TIMER_EN,
	output logic [5:0] CH_IRQ,
	output logic [5:0] CH_DMA,
	output logic UPDATE_IRQ
);
	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	// Timer run state and reload buffer mode
	logic enable;
	logic reload_buffer_enable;
	// Written reload value, waits here while buffered
	logic [COUNT_W-1:0] auto_reload_value;
	// Programmed repeat count and its two mask bits
	logic [REPEAT_W-1:0] repeat_count;
	logic overflow_count_mask;
	logic underflow_count_mask;
	// Live repetition counter, counts down to zero
	logic [REPEAT_W-1:0] rep_left;
	// Compare-only fourth channel, written and active copies
	logic [COUNT_W-1:0] internal_compare_channel;
	logic [COUNT_W-1:0] intcmp_active;
	// Per-channel control, value and active value
	logic [6:0] chcr [6];
	logic [COUNT_W-1:0] ccr [6];
	logic [COUNT_W-1:0] ccr_active [6];
	// Status flags, cleared by writing 0 to the clear word
	logic [5:0] channel_event_flag;
	logic [5:0] channel_recapture_flag;
	logic update_flag;
	// Pin synchroniser stages and edge history
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [5:0] sync3;
	// Capture strobes, hardware and software
	logic [5:0] cap;
	logic [5:0] sw_cap;
	// Decoded register writes
	logic wr_ctrl;
	logic wr_reload;
	logic wr_repeat;
	logic wr_intcmp;
	logic wr_clear;
	logic sw_update;
	logic start;
	// Repetition tick and combined update cause
	logic rep_tick;
	logic upd;

	// ----------------------------------------
	// Decode and event logic
	// ----------------------------------------
	// Write strobes per register
	assign wr_ctrl = WR && ADDR == trrc_pkg::ADDR_CTRL;
	assign wr_reload = WR && ADDR == trrc_pkg::ADDR_RELOAD;
	assign wr_repeat = WR && ADDR == trrc_pkg::ADDR_REPEAT;
	assign wr_intcmp = WR && ADDR == trrc_pkg::ADDR_INTCMP;
	assign wr_clear = WR && ADDR == trrc_pkg::ADDR_CLEAR;
	// Update request bit is a pulse; it is never stored
	assign sw_update = wr_ctrl && WDATA[trrc_pkg::CTRL_SWUPD];
	// Start only on the 0 to 1 step of the enable bit
	assign start = wr_ctrl && WDATA[trrc_pkg::CTRL_EN] && !enable;

	// Counting tick of the repetition counter, per mask bits
	// Direction only matters in edge-aligned counting;
	// center-aligned mode counts both overflow and underflow.
	always_comb
	begin
		rep_tick = 1'b0;
		if (OVERFLOW && (CENTER_MODE || !DOWN_DIR) && !overflow_count_mask)
			rep_tick = 1'b1;
		if (UNDERFLOW && (CENTER_MODE || DOWN_DIR) && !underflow_count_mask)
			rep_tick = 1'b1;
	end

	// Update when repetition reaches zero, or forced by software or slave reset
	// Forced causes ignore the repetition counter on purpose.
	assign upd = sw_update || SLAVE_RESET || (rep_tick && rep_left == '0);

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Enable, buffer mode, repeat count and masks
	// A new repeat count waits for start, forced update or the next wrap at zero.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			enable <= 1'b0;
			reload_buffer_enable <= 1'b0;
			repeat_count <= '0;
			overflow_count_mask <= 1'b0;
			underflow_count_mask <= 1'b0;
			internal_compare_channel <= '0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				enable <= WDATA[trrc_pkg::CTRL_EN];
				reload_buffer_enable <= WDATA[trrc_pkg::CTRL_BUF];
			end
			if (wr_repeat)
			begin
				repeat_count <= WDATA[REPEAT_W-1:0];
				overflow_count_mask <= WDATA[trrc_pkg::REPEAT_OVF_MASK];
				underflow_count_mask <= WDATA[trrc_pkg::REPEAT_UNF_MASK];
			end
			// Compare only: no capture path reaches this register
			if (wr_intcmp)
				internal_compare_channel <= WDATA[COUNT_W-1:0];
		end
	end

	// Reload value: written copy and active copy
	// Buffered write plus update in one cycle keeps the older value;
	// the new one moves at the following update.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			auto_reload_value <= trrc_pkg::RELOAD_RST;
			ACTIVE_RELOAD <= trrc_pkg::RELOAD_RST;
		end
		else
		begin
			if (wr_reload)
				auto_reload_value <= WDATA[COUNT_W-1:0];
			if (wr_reload && (!enable || !reload_buffer_enable))
				ACTIVE_RELOAD <= WDATA[COUNT_W-1:0];
			else if (upd)
				ACTIVE_RELOAD <= auto_reload_value;
		end
	end

	// Repetition counter; wraps to repeat count after each zero
	// A repeat count of N gives one update per N+1 counted ticks.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			rep_left <= '0;
		else if (start || sw_update || SLAVE_RESET)
			rep_left <= repeat_count;
		else if (rep_tick)
		begin
			if (rep_left == '0)
				rep_left <= repeat_count;
			else
				rep_left <= rep_left - 1'b1;
		end
	end

	// Single-cycle update pulse and update flag
	// Update irq follows every event; masking is left to the system.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			UPDATE_EVENT <= 1'b0;
			update_flag <= 1'b0;
			UPDATE_IRQ <= 1'b0;
			TIMER_EN <= 1'b0;
			intcmp_active <= '0;
		end
		else
		begin
			UPDATE_EVENT <= upd;
			TIMER_EN <= wr_ctrl ? WDATA[trrc_pkg::CTRL_EN] : enable;
			// Set wins over a clear in the same cycle
			if (upd)
				update_flag <= 1'b1;
			else if (wr_clear && !WDATA[trrc_pkg::STATUS_UPD])
				update_flag <= 1'b0;
			UPDATE_IRQ <= upd;
			if (upd)
				intcmp_active <= internal_compare_channel;
		end
	end

	// ----------------------------------------
	// Capture channels 1A,1B,2A,2B,3A,3B
	// ----------------------------------------
	// Six independent inputs; pairs share no state.
	// Capture mode only: compare outputs live elsewhere.
	// Filtering is left out; pins must be clean.
	genvar i;
	generate
		for (i = 0; i < 6; i++)
		begin : g_ch
			logic rise;
			logic fall;
			logic [1:0] bks;
			logic wr_cr;
			assign bks = chcr[i][trrc_pkg::CHCR_BKS+1:trrc_pkg::CHCR_BKS];
			assign rise = sync2[i] && !sync3[i];
			assign fall = !sync2[i] && sync3[i];
			assign wr_cr = WR && ADDR == trrc_pkg::ADDR_CHCR + 8'(i);
			// Software request bit forced into capture handling in same cycle
			assign sw_cap[i] = chcr[i][trrc_pkg::CHCR_CCG];
			// Edge qualifies only in capture mode; timer enable plays no part
			assign cap[i] = chcr[i][trrc_pkg::CHCR_CS] && (sw_cap[i]
				|| (bks == trrc_pkg::EDGE_RISE && rise)
				|| (bks == trrc_pkg::EDGE_FALL && fall)
				|| (bks == trrc_pkg::EDGE_BOTH && (rise || fall)));

			// Two-flop synchroniser then edge history
			// Costs three cycles of latency but guards against metastability.
			always_ff @(posedge REF_CLK)
			begin
				if (!RST_N)
				begin
					sync1[i] <= 1'b0;
					sync2[i] <= 1'b0;
					sync3[i] <= 1'b0;
				end
				else
				begin
					sync1[i] <= CH_IN[i];
					sync2[i] <= sync1[i];
					sync3[i] <= sync2[i];
				end
			end

			// Control word; request bit self-clears after one cycle
			always_ff @(posedge REF_CLK)
			begin
				if (!RST_N)
					chcr[i] <= '0;
				else if (wr_cr)
					chcr[i] <= WDATA[6:0];
				else
					chcr[i][trrc_pkg::CHCR_CCG] <= 1'b0;
			end

			// Compare/capture value and active copy
			// Capture wins over a software write in the same cycle.
			always_ff @(posedge REF_CLK)
			begin
				if (!RST_N)
				begin
					ccr[i] <= '0;
					ccr_active[i] <= '0;
				end
				else
				begin
					if (cap[i])
						ccr[i] <= MAIN_COUNTER;
					else if (WR && ADDR == trrc_pkg::ADDR_CCR + 8'(i))
						ccr[i] <= WDATA[COUNT_W-1:0];
					if (upd || !chcr[i][trrc_pkg::CHCR_BUFE])
						ccr_active[i] <= ccr[i];
				end
			end

			// Flags, interrupt and DMA requests
			// Recapture looks at the flag before this capture sets it.
			always_ff @(posedge REF_CLK)
			begin
				if (!RST_N)
				begin
					channel_event_flag[i] <= 1'b0;
					channel_recapture_flag[i] <= 1'b0;
					CH_IRQ[i] <= 1'b0;
					CH_DMA[i] <= 1'b0;
				end
				else
				begin
					if (cap[i])
						channel_event_flag[i] <= 1'b1;
					else if (wr_clear && !WDATA[trrc_pkg::STATUS_EVT+i])
						channel_event_flag[i] <= 1'b0;
					if (cap[i] && channel_event_flag[i])
						channel_recapture_flag[i] <= 1'b1;
					else if (wr_clear && !WDATA[trrc_pkg::STATUS_RECAP+i])
						channel_recapture_flag[i] <= 1'b0;
					CH_IRQ[i] <= cap[i] && chcr[i][trrc_pkg::CHCR_CIE];
					CH_DMA[i] <= cap[i] && chcr[i][trrc_pkg::CHCR_CDE];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Read data one cycle after the strobe; zero when idle or unmapped
	// Reads have no side effects; flags clear only through the clear word.
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			RDATA <= '0;
		else if (!RD)
			RDATA <= '0;
		else if (ADDR == trrc_pkg::ADDR_CTRL)
			RDATA <= {30'h0, reload_buffer_enable, enable};
		else if (ADDR == trrc_pkg::ADDR_RELOAD)
			RDATA <= {16'h0, auto_reload_value};
		else if (ADDR == trrc_pkg::ADDR_REPEAT)
			RDATA <= {22'h0, underflow_count_mask, overflow_count_mask, repeat_count};
		else if (ADDR == trrc_pkg::ADDR_STATUS)
			RDATA <= {19'h0, channel_recapture_flag, channel_event_flag, update_flag};
		else if (ADDR == trrc_pkg::ADDR_INTCMP)
			RDATA <= {16'h0, internal_compare_channel};
		else if (ADDR[7:3] == trrc_pkg::ADDR_CHCR[7:3] && ADDR[2:0] < 3'h6)
			RDATA <= {25'h0, chcr[ADDR[2:0]]};
		else if (ADDR[7:3] == trrc_pkg::ADDR_CCR[7:3] && ADDR[2:0] < 3'h6)
			RDATA <= {16'h0, ccr[ADDR[2:0]]};
		else if (ADDR[7:3] == trrc_pkg::ADDR_ACT[7:3] && ADDR[2:0] < 3'h6)
			RDATA <= {16'h0, ccr_active[ADDR[2:0]]};
		else if (ADDR == trrc_pkg::ADDR_INTCMP_ACT)
			RDATA <= {16'h0, intcmp_active};
		else
			RDATA <= '0;
	end
endmodule

// file: pkg/trrc_pkg.sv
// Constants for the timer reload, repetition and capture block.
// Assumes a host bus of 8-bit word addresses and 32-bit data, one clock.
// Operation
// - Stopped or unbuffered: written reload value goes active at once.
// - Running and buffered: written reload value goes active at update event.
// - Starting the timer loads the repeat count into the repetition counter.
// - Overflow decrements repetition counter unless overflow mask bit is 1; the code ignores it in edge-aligned down counting.
// - Underflow decrements repetition counter unless underflow mask bit is 1; the code ignores it in edge-aligned up counting.
// - Nonzero repeat count: overflow/underflow updates only when counter reaches zero.
// - Software update or slave reset updates at once and reloads repetition counter.
// - Update event transfers reload and compare values, raises update interrupt.
// - Three channels, each with A and B compare/capture registers and buffers.
// - Six capture inputs, six PWM outputs or three complementary pairs.
// - Internal fourth channel: one compare register, no pin, never captures.
// - Function select 1 puts a channel in capture mode, any counting mode.
// - Software capture request latches counter and clears itself.
// - Selected valid input edge latches counter into the channel register.
// - Edge select: 00 off, 01 rising, 10 falling, 11 both.
// - Each capture sets event flag; interrupt follows when enabled.
// - Each capture issues a DMA request when DMA is enabled.
// - Capture with event flag still set also sets recapture flag.
// - Writing 0 to a clear-register bit clears that status flag.
// - Captures work even while the timer is stopped.
// - Main counter is 16 bits wide.
// - Update event lasts exactly one clock cycle.
package trrc_pkg;
	localparam int COUNT_W = 16;
	localparam int REPEAT_W = 8;
	localparam int NCH = 6;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RELOAD = 8'h01;
	localparam logic [7:0] ADDR_REPEAT = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_CLEAR = 8'h04;
	localparam logic [7:0] ADDR_INTCMP = 8'h05;
	localparam logic [7:0] ADDR_CHCR = 8'h08;
	localparam logic [7:0] ADDR_CCR = 8'h10;
	localparam logic [7:0] ADDR_ACT = 8'h18;
	localparam logic [7:0] ADDR_INTCMP_ACT = 8'h1E;
	localparam int CTRL_EN = 0;
	localparam int CTRL_BUF = 1;
	localparam int CTRL_SWUPD = 2;
	localparam int REPEAT_OVF_MASK = 8;
	localparam int REPEAT_UNF_MASK = 9;
	localparam int CHCR_CS = 0;
	localparam int CHCR_BKS = 1;
	localparam int CHCR_CCG = 3;
	localparam int CHCR_CIE = 4;
	localparam int CHCR_CDE = 5;
	localparam int CHCR_BUFE = 6;
	localparam int STATUS_UPD = 0;
	localparam int STATUS_EVT = 1;
	localparam int STATUS_RECAP = 7;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// file: testbench/test_timer_reload_repeat_capture.sv
// Bench for reload buffering, repetition counter and capture.
// Assumes trrc_core, its checker and the far-side model.
`timescale 1ns/1ns
module test_timer_reload_repeat_capture;
	logic REF_CLK, RST_N, WR, RD, OVERFLOW, UNDERFLOW, CENTER_MODE, DOWN_DIR, SLAVE_RESET, run;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA;
	logic [5:0] pin_req, CH_IN, CH_IRQ, CH_DMA;
	logic [15:0] MAIN_COUNTER, ACTIVE_RELOAD, v;
	logic [15:0] exp_ccr [6];
	logic UPDATE_EVENT, TIMER_EN, UPDATE_IRQ;
	logic [1:0] m;
	int err_total = 0, compares = 0, irq_n = 0, dma_n = 0, n, ei = 0, ed = 0;
	trrc_core u_trrc_core (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .MAIN_COUNTER(MAIN_COUNTER), .OVERFLOW(OVERFLOW),
		.UNDERFLOW(UNDERFLOW), .CENTER_MODE(CENTER_MODE), .DOWN_DIR(DOWN_DIR),
		.SLAVE_RESET(SLAVE_RESET), .CH_IN(CH_IN), .UPDATE_EVENT(UPDATE_EVENT),
		.ACTIVE_RELOAD(ACTIVE_RELOAD), .TIMER_EN(TIMER_EN), .CH_IRQ(CH_IRQ),
		.CH_DMA(CH_DMA), .UPDATE_IRQ(UPDATE_IRQ));
	trrc_far_side u_trrc_far_side (.clk(REF_CLK), .run(run), .pin_req(pin_req),
		.count(MAIN_COUNTER), .pins(CH_IN));
	// ----
	// Clock, pulse tallies, watchdog
	// ----
	always #50 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK)
	begin
		irq_n <= irq_n + $countones(CH_IRQ);
		dma_n <= dma_n + $countones(CH_DMA);
	end
	// Run needs about 840 cycles; some 24 times that is a hang
	initial
	begin
		#2000000;
		err_total++;
		print_verdict;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1;
		chk(nm, e, RDATA);
	endtask
	// One overflow or underflow tick, event seen the cycle after
	task automatic tk(input logic o, input logic u, input logic e);
		@(posedge REF_CLK);
		OVERFLOW <= o;
		UNDERFLOW <= u;
		@(posedge REF_CLK);
		OVERFLOW <= 1'b0;
		UNDERFLOW <= 1'b0;
		#1;
		chk("update", {31'h0, e}, {31'h0, UPDATE_EVENT});
	endtask
	// Counter steps once, then freezes
	task automatic step;
		run <= 1'b1;
		@(posedge REF_CLK);
		run <= 1'b0;
		#1;
		v = MAIN_COUNTER;
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial
	begin
		{REF_CLK, RST_N, WR, RD, OVERFLOW, UNDERFLOW, CENTER_MODE, DOWN_DIR, SLAVE_RESET} = 0;
		{ADDR, WDATA, pin_req} = 0;
		run = 1'b1;
		repeat (3) @(posedge REF_CLK);
		RST_N <= 1'b1;
		#1;
		chk("reload reset", 32'hFFFF, {16'h0, ACTIVE_RELOAD});
		rd(8'h07, 32'h0, "unmapped");
		wr(trrc_pkg::ADDR_RELOAD, 32'h1234);
		chk("reload", 32'h1234, {16'h0, ACTIVE_RELOAD});
		wr(trrc_pkg::ADDR_REPEAT, 32'h2);
		wr(trrc_pkg::ADDR_CTRL, 32'h3);
		chk("timer on", 32'h1, {31'h0, TIMER_EN});
		wr(trrc_pkg::ADDR_RELOAD, 32'h5678);
		chk("reload held", 32'h1234, {16'h0, ACTIVE_RELOAD});
		tk(1, 0, 0);
		tk(1, 0, 0);
		tk(1, 0, 1);
		chk("reload moved", 32'h5678, {16'h0, ACTIVE_RELOAD});
		wr(trrc_pkg::ADDR_INTCMP, 32'hA5A5);
		wr(trrc_pkg::ADDR_REPEAT, 32'h201);
		wr(trrc_pkg::ADDR_CTRL, 32'h7);
		chk("update sw", 32'h1, {31'h0, UPDATE_EVENT});
		rd(trrc_pkg::ADDR_INTCMP_ACT, 32'hA5A5, "intcmp active");
		DOWN_DIR <= 1'b1;
		tk(0, 1, 0);
		tk(0, 1, 0);
		wr(trrc_pkg::ADDR_REPEAT, 32'h1);
		tk(0, 1, 0);
		tk(0, 1, 1);
		CENTER_MODE <= 1'b1;
		wr(trrc_pkg::ADDR_REPEAT, 32'h100);
		@(posedge REF_CLK);
		SLAVE_RESET <= 1'b1;
		@(posedge REF_CLK);
		SLAVE_RESET <= 1'b0;
		#1;
		chk("update slave", 32'h1, {31'h0, UPDATE_EVENT});
		chk("update irq", 32'h1, {31'h0, UPDATE_IRQ});
		tk(1, 0, 0);
		tk(0, 1, 1);
		rd(trrc_pkg::ADDR_STATUS, 32'h1, "status update");
		wr(trrc_pkg::ADDR_CTRL, 32'h0);
		chk("timer off", 32'h0, {31'h0, TIMER_EN});
		wr(trrc_pkg::ADDR_CLEAR, 32'h0);
		step;
		wr(trrc_pkg::ADDR_CHCR, 32'h9);
		rd(trrc_pkg::ADDR_CCR, {16'h0, v}, "sw capture");
		rd(trrc_pkg::ADDR_CHCR, 32'h1, "request clear");
		exp_ccr = '{v, 0, 0, 0, 0, 0};
		// Every channel, every edge code, then capture mode off
		for (int c = 0; c < 6; c++)
			for (int k = 0; k < 5; k++)
			begin
				m = (k == 4) ? 2'h3 : 2'(k);
				wr(trrc_pkg::ADDR_CLEAR, 32'h0);
				wr(trrc_pkg::ADDR_CHCR + 8'(c), {26'h0, ~c[0], c[0], 1'b0, m, k != 4});
				step;
				pin_req[c] <= 1'b1;
				repeat (6) @(posedge REF_CLK);
				if (m[0] && k < 4)
					exp_ccr[c] = v;
				step;
				pin_req[c] <= 1'b0;
				repeat (6) @(posedge REF_CLK);
				if (m[1] && k < 4)
					exp_ccr[c] = v;
				n = (k < 4) ? m[0] + m[1] : 0;
				ei += c[0] ? n : 0;
				ed += c[0] ? 0 : n;
				rd(trrc_pkg::ADDR_CCR + 8'(c), {16'h0, exp_ccr[c]}, "ccr");
				rd(trrc_pkg::ADDR_STATUS, (32'(n != 0) << (1 + c)) | (32'(n == 2) << (7 + c)), "status");
				wr(trrc_pkg::ADDR_CLEAR, ~(32'h2 << c));
				rd(trrc_pkg::ADDR_STATUS, 32'(n == 2) << (7 + c), "status cleared");
			end
		chk("irq pulses", ei, irq_n);
		chk("dma pulses", ed, dma_n);
		print_verdict;
	end
endmodule

// file: testbench/trrc_checker.sv
// Checker for update, reload and capture pulse relations.
// Bound to trrc_core; sees its ports only, one clock.
`timescale 1ns/1ns
module trrc_checker
#(
	parameter int COUNT_W = 16
)
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic OVERFLOW,
	input wire logic UNDERFLOW,
	input wire logic SLAVE_RESET,
	input wire logic UPDATE_EVENT,
	input wire logic UPDATE_IRQ,
	input wire logic TIMER_EN,
	input wire logic [COUNT_W-1:0] ACTIVE_RELOAD,
	input wire logic [5:0] CH_IRQ,
	input wire logic [5:0] CH_DMA
);
	// ----
	// Helpers
	// ----
	logic upd_wr;
	logic reload_wr;
	// Decoded software update and reload writes
	assign upd_wr = WR && ADDR == trrc_pkg::ADDR_CTRL && WDATA[trrc_pkg::CTRL_SWUPD];
	assign reload_wr = WR && ADDR == trrc_pkg::ADDR_RELOAD;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	// ----
	// Assertions
	// ----
	AST_UPD_PULSE: assert property (UPDATE_EVENT |=> !UPDATE_EVENT)
		else $error("update event longer than one cycle");
	AST_SWUPD_NOW: assert property (upd_wr |=> UPDATE_EVENT)
		else $error("software update gave no event");
	AST_SLAVE_NOW: assert property (SLAVE_RESET |=> UPDATE_EVENT && UPDATE_IRQ)
		else $error("slave reset gave no event");
	AST_UIRQ: assert property (UPDATE_IRQ == UPDATE_EVENT)
		else $error("update irq apart from event");
	AST_CAUSE: assert property (UPDATE_EVENT |-> $past(upd_wr || SLAVE_RESET || OVERFLOW || UNDERFLOW))
		else $error("update event without cause");
	AST_RELOAD_NOW: assert property (reload_wr && !TIMER_EN |=> ACTIVE_RELOAD == $past(WDATA[COUNT_W-1:0]))
		else $error("stopped reload write not active");
	AST_RELOAD_HOLD: assert property ($changed(ACTIVE_RELOAD) |-> UPDATE_EVENT || $past(reload_wr))
		else $error("reload changed off update");
	AST_IRQ_PULSE: assert property (|CH_IRQ |=> (CH_IRQ & $past(CH_IRQ)) == 6'h00)
		else $error("channel irq longer than one cycle");
	AST_DMA_PULSE: assert property (|CH_DMA |=> (CH_DMA & $past(CH_DMA)) == 6'h00)
		else $error("channel dma longer than one cycle");
	// Main scenarios reached
	COV_UPD: cover property (UPDATE_EVENT);
	COV_IRQ: cover property (|CH_IRQ);
	COV_DMA: cover property (|CH_DMA);
endmodule
bind trrc_core trrc_checker #(.COUNT_W(COUNT_W)) u_trrc_checker (.REF_CLK, .RST_N, .ADDR, .WDATA,
	.WR, .OVERFLOW, .UNDERFLOW, .SLAVE_RESET, .UPDATE_EVENT, .UPDATE_IRQ, .TIMER_EN,
	.ACTIVE_RELOAD, .CH_IRQ, .CH_DMA);

// file: testbench/trrc_far_side.sv
// Far-side model: channel pins and a freezable main counter.
// Bench requests levels; outputs change just after rising edges.
`timescale 1ns/1ns
module trrc_far_side
(
	input wire logic clk,
	input wire logic run,
	input wire logic [5:0] pin_req,
	output logic [15:0] count = 16'h0000,
	output logic [5:0] pins = 6'h00
);
	// Frozen counter gives a known capture value
	always @(posedge clk)
	begin
		if (run)
			count <= count + 16'h0001;
		pins <= pin_req;
	end
endmodule
